// file: pfc_defines.vh
// register offsets, field positions, reset values and codes of the function configuration group
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
`define PFC_ADDR_FUNC_ONE 8'h16
`define PFC_ADDR_FUNC_TWO 8'h17
`define PFC_ADDR_FUNC_THREE 8'h1e
`define PFC_ADDR_RATIO_BASE 8'h06
`define PFC_ADDR_RATIO_LAST 8'h15
`define PFC_ADDR_DEVCFG_ONE 8'h03
`define PFC_ADDR_DEVCFG_TWO 8'h04
`define PFC_ADDR_GLOBAL 8'h05
`define PFC_BIT_SKIP 7
`define PFC_BIT_LOCKDRV 6
`define PFC_BIT_PRESC_HI 4
`define PFC_BIT_PRESC_LO 3
`define PFC_BIT_OUTUNL 4
`define PFC_BIT_LFFMT 3
`define PFC_BIT_BW_HI 6
`define PFC_BIT_BW_LO 4
`define PFC_MASK_FUNC_ONE 8'hd8
`define PFC_MASK_FUNC_TWO 8'h18
`define PFC_MASK_FUNC_THREE 8'h70
`define PFC_RST_FUNC_ONE 8'h00
`define PFC_RST_FUNC_TWO 8'h00
`define PFC_RST_FUNC_THREE 8'h00
`define PFC_AUX_LOCK 2'h3
`define PFC_PRESC_DIV4 2'h0
`define PFC_PRESC_DIV2 2'h1
`define PFC_PRESC_DIV1 2'h2
`define PFC_FMT_HIMUL 1'h0
`define PFC_FMT_HIACC 1'h1
`endif

// file: pfc_sync3.v
// three-stage input synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module pfc_sync3 (
   input wire clk_sys, // system clock
   input wire rstn, // async reset, active low
   input wire din, // asynchronous level
   output reg dout // filtered synchronous level
);
   reg s1; // first stage, read only by s2
   reg s2; // second stage
   reg s3; // third stage
   // shift chain and agreement filter
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3; // stages agree: take the change
         end
      end
   end
endmodule

// file: pfc_function_config.v
// function configuration register group with lock indicator, prescaler and ratio format logic
`timescale 1ns/1ps
`include "pfc_defines.vh"
// How it works
// - skip bit lets lock survive missing sync pulses
// - lock driver 0: push-pull, high when unlocked
// - lock driver 1: open drain, low unlocked
// - clock on aux pin ignores lock driver
// - prescale codes divide by 4, 2, 1
// - unlock bit 0 forces clock outputs low while unlocked
// - unlock bit 1 keeps outputs always on
// - hybrid mode: format bit picks 20.12/12.20
// - static mode always uses 12.20 format
// - bandwidth code 000..111 gives 1..128 Hz
// - aux pin is lock indicator at code 11
// - ratio source 1 selects hybrid mode
// - ratio is four bytes, MSB first
module pfc_function_config (
   input wire clk_sys, // system clock, 100 MHz
   input wire rstn, // async reset, active low
   input wire regWrite, // one-cycle register write strobe
   input wire [7:0] regAddr, // register address
   input wire [7:0] regWdata, // write data
   input wire [7:0] regRaddr, // read address
   output reg [7:0] regRdata, // registered read data
   input wire [1:0] aux_source_select, // aux pin source code
   input wire ratio_source_select, // 1 = hybrid mode
   input wire [1:0] ratioIndex, // selected user ratio index
   input wire pllLocked, // lock status from analog loop, asynchronous
   input wire syncPulseMissing, // sync input pulse gap seen, asynchronous
   input wire auxClock, // clock value to route to aux pin
   output reg auxPinOut, // aux pin output value
   output reg auxPinOe, // aux pin output enable
   output reg clockOutEnable, // clock output gate, low forces outputs low
   output reg skip_tolerance_enable, // clock skipping mode active
   output reg holdLock, // keep lock through missing pulses
   output reg [2:0] refDivide, // timing reference divide factor
   output reg prescaleReserved, // reserved prescaler code written
   output reg ratioFractionHigh, // 1 = 12.20, 0 = 20.12
   output reg [31:0] user_ratio, // selected 32-bit ratio
   output reg [7:0] bandwidthHz, // applied minimum loop bandwidth in Hz
   output reg bandwidthPending // new bandwidth waits for unlock
);
   reg [7:0] funcOne; // first function configuration register
   reg [7:0] funcTwo; // second function configuration register
   reg [7:0] funcThree; // third function configuration register
   reg [7:0] ratioMem [0:15]; // four user ratios, four bytes each
   reg [2:0] bwApplied; // bandwidth code in use by the loop
   wire lockedSync; // synchronised lock status
   wire missSync; // synchronised pulse gap indication
   wire auxIsLock; // aux pin carries lock indicator
   wire [1:0] presc; // prescale field
   wire [3:0] ratioBase; // first byte index of the selected ratio
   reg [7:0] next_rdata; // read mux output
   integer i; // memory reset index
   wire auxClockSync; // synchronised aux clock level
   wire [7:0] wrOffset; // write address minus the ratio base
   wire [7:0] rdOffset; // read address minus the ratio base
   wire wrRatioHit; // write lands in the ratio bytes
   wire rdRatioHit; // read lands in the ratio bytes
   wire [3:0] byteOne; // second byte index of the selected ratio
   wire [3:0] byteTwo; // third byte index of the selected ratio
   wire [3:0] byteThree; // fourth byte index of the selected ratio

   assign auxIsLock = (aux_source_select == `PFC_AUX_LOCK);
   assign presc = funcOne[`PFC_BIT_PRESC_HI:`PFC_BIT_PRESC_LO];
   assign ratioBase = {ratioIndex, 2'h0};
   // ratio bytes sit at one address each, sixteen in a row; the offset keeps
   // the slot index right across the 0x0f to 0x10 address boundary
   assign wrOffset = regAddr - `PFC_ADDR_RATIO_BASE;
   assign rdOffset = regRaddr - `PFC_ADDR_RATIO_BASE;
   assign wrRatioHit = (regAddr >= `PFC_ADDR_RATIO_BASE) && (regAddr <= `PFC_ADDR_RATIO_LAST);
   assign rdRatioHit = (regRaddr >= `PFC_ADDR_RATIO_BASE) && (regRaddr <= `PFC_ADDR_RATIO_LAST);
   // most significant byte sits at the lowest address of the group
   assign byteOne = ratioBase + 4'h1;
   assign byteTwo = ratioBase + 4'h2;
   assign byteThree = ratioBase + 4'h3;

   // lock status comes from the analog domain
   pfc_sync3 lockSyncInst (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .din(pllLocked),
      .dout(lockedSync)
   );

   // pulse gap indication comes from the sync input detector
   pfc_sync3 missSyncInst (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .din(syncPulseMissing),
      .dout(missSync)
   );

   // the routed clock comes from another clock domain; the filter adds about
   // four cycles of delay and limits how fast a routed clock can be followed
   pfc_sync3 auxSyncInst (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .din(auxClock),
      .dout(auxClockSync)
   );

   // register writes; reserved bits are masked off
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         funcOne <= `PFC_RST_FUNC_ONE;
         funcTwo <= `PFC_RST_FUNC_TWO;
         funcThree <= `PFC_RST_FUNC_THREE;
         for (i = 0; i < 16; i = i + 1) begin
            ratioMem[i] <= 8'h00;
         end
      end else if (regWrite) begin
         case (regAddr)
            `PFC_ADDR_FUNC_ONE: funcOne <= regWdata & `PFC_MASK_FUNC_ONE;
            `PFC_ADDR_FUNC_TWO: funcTwo <= regWdata & `PFC_MASK_FUNC_TWO;
            `PFC_ADDR_FUNC_THREE: funcThree <= regWdata & `PFC_MASK_FUNC_THREE;
            default: begin
               // ratio bytes, one address each
               if (wrRatioHit) begin
                  ratioMem[wrOffset[3:0]] <= regWdata;
               end
            end
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      next_rdata = 8'h00;
      case (regRaddr)
         `PFC_ADDR_FUNC_ONE: next_rdata = funcOne;
         `PFC_ADDR_FUNC_TWO: next_rdata = funcTwo;
         `PFC_ADDR_FUNC_THREE: next_rdata = funcThree;
         default: begin
            if (rdRatioHit) begin
               next_rdata = ratioMem[rdOffset[3:0]];
            end
         end
      endcase
   end

   // all outputs registered
   // derived outputs lag the register state by one cycle, bandwidthHz by two; anything fed by the
   // lock status lags the pin by the synchroniser delay as well, so a short
   // lock glitch never reaches the aux pin or the clock gate
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
         auxPinOut <= 1'b0;
         auxPinOe <= 1'b0;
         clockOutEnable <= 1'b0;
         skip_tolerance_enable <= 1'b0;
         holdLock <= 1'b0;
         refDivide <= 3'h4;
         prescaleReserved <= 1'b0;
         ratioFractionHigh <= 1'b1;
         user_ratio <= 32'h00000000;
         bwApplied <= 3'h0;
         bandwidthHz <= 8'h01;
         bandwidthPending <= 1'b0;
      end else begin
         regRdata <= next_rdata;
         // skipping mode holds lock across pulse gaps
         skip_tolerance_enable <= funcOne[`PFC_BIT_SKIP];
         holdLock <= funcOne[`PFC_BIT_SKIP] & missSync & lockedSync;
         // aux pin driver
         if (auxIsLock) begin
            if (!funcOne[`PFC_BIT_LOCKDRV]) begin
               auxPinOut <= ~lockedSync;
               auxPinOe <= 1'b1;
            end else begin
               auxPinOut <= 1'b0;
               auxPinOe <= ~lockedSync;
            end
         end else begin
            auxPinOut <= auxClockSync;
            auxPinOe <= 1'b1;
         end
         // clock output gating while unlocked
         clockOutEnable <= funcTwo[`PFC_BIT_OUTUNL] | lockedSync;
         // timing reference prescaler
         case (presc)
            `PFC_PRESC_DIV4: begin
               refDivide <= 3'h4;
               prescaleReserved <= 1'b0;
            end
            `PFC_PRESC_DIV2: begin
               refDivide <= 3'h2;
               prescaleReserved <= 1'b0;
            end
            `PFC_PRESC_DIV1: begin
               refDivide <= 3'h1;
               prescaleReserved <= 1'b0;
            end
            default: begin
               refDivide <= refDivide; // reserved code keeps last divide
               prescaleReserved <= 1'b1;
            end
         endcase
         // ratio format
         if (ratio_source_select) begin
            ratioFractionHigh <= funcTwo[`PFC_BIT_LFFMT];
         end else begin
            ratioFractionHigh <= `PFC_FMT_HIACC;
         end
         user_ratio <= {ratioMem[ratioBase], ratioMem[byteOne],
                        ratioMem[byteTwo], ratioMem[byteThree]};
         // bandwidth applied only while unlocked; a locked loop keeps its
         // bandwidth and the new code waits for the next unlock
         if (!lockedSync) begin
            bwApplied <= funcThree[`PFC_BIT_BW_HI:`PFC_BIT_BW_LO];
         end
         bandwidthHz <= 8'h01 << bwApplied;
         bandwidthPending <= lockedSync && (bwApplied != funcThree[`PFC_BIT_BW_HI:`PFC_BIT_BW_LO]);
      end
   end
endmodule

// file: pfc_host_model.sv
// host model that drives the register write and read ports
`timescale 1ns/1ps
module pfc_host_model (
   input wire clk_sys, // system clock
   input wire [7:0] regRdata, // read data
   output reg regWrite, // write strobe
   output reg [7:0] regAddr, // write address
   output reg [7:0] regWdata, // write data
   output reg [7:0] regRaddr // read address
);
   initial {regWrite, regAddr, regWdata, regRaddr} = 25'h0;
   // one strobe; address and data show inverted values once released
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         regWrite <= 1'b1;
         regAddr <= a;
         regWdata <= d;
         @(posedge clk_sys);
         regWrite <= 1'b0;
         regAddr <= ~a;
         regWdata <= ~d;
      end
   endtask
   // read data is registered one edge after the address is taken
   task rd(input [7:0] a, output [7:0] q);
      begin
         @(posedge clk_sys);
         regRaddr <= a;
         @(posedge clk_sys);
         #1 q = regRdata;
      end
   endtask
endmodule

// file: pfc_function_config_props.sv
// checker for the function configuration ports
`timescale 1ns/1ps
module pfc_fc_props (
   input wire clk_sys, // clock
   input wire rstn, // reset
   input wire regWrite, // strobe
   input wire [7:0] regAddr, // address
   input wire [7:0] regWdata, // data
   input wire [7:0] regRaddr, // read address
   input wire [7:0] regRdata, // read data
   input wire [1:0] aux_source_select, // aux code
   input wire ratio_source_select, // mode
   input wire pllLocked, // lock
   input wire auxPinOe, // aux enable
   input wire clockOutEnable, // clock gate
   input wire skip_tolerance_enable, // skip mode
   input wire [2:0] refDivide, // divide
   input wire prescaleReserved, // reserved code
   input wire ratioFractionHigh, // format
   input wire [7:0] bandwidthHz // bandwidth
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // write to the first function register
   sequence s_wr16; regWrite && regAddr == 8'h16; endsequence
   property p_skip; s_wr16 |-> ##2 skip_tolerance_enable == $past(regWdata[7], 2); endproperty
   a_skip: assert property (p_skip) else $error("skip bit not applied");
   property p_div; s_wr16 ##0 regWdata[4:3] != 2'h3 |-> ##2 refDivide == (3'h4 >> $past(regWdata[4:3], 2)); endproperty
   a_div: assert property (p_div) else $error("prescale divide wrong");
   property p_resv; s_wr16 ##0 regWdata[4:3] == 2'h3 |-> ##2 prescaleReserved && $stable(refDivide); endproperty
   a_resv: assert property (p_resv) else $error("reserved prescale mishandled");
   property p_mask; s_wr16 ##2 (regRaddr == 8'h16 && !regWrite) |=> regRdata == ($past(regWdata, 3) & 8'hd8); endproperty
   a_mask: assert property (p_mask) else $error("reserved bits not masked");
   property p_clk; pllLocked [*8] |-> clockOutEnable; endproperty
   a_clk: assert property (p_clk) else $error("clock gated while locked");
   property p_aux; (aux_source_select != 2'h3) [*3] |-> auxPinOe; endproperty
   a_aux: assert property (p_aux) else $error("clock source not driven");
   property p_fmt; (!ratio_source_select) [*3] |-> ratioFractionHigh; endproperty
   a_fmt: assert property (p_fmt) else $error("static mode format wrong");
   property p_bw; $onehot(bandwidthHz); endproperty
   a_bw: assert property (p_bw) else $error("bandwidth not a power of two");
   property p_bwhold; pllLocked [*8] |=> $stable(bandwidthHz); endproperty
   a_bwhold: assert property (p_bwhold) else $error("bandwidth changed while locked");
endmodule
bind pfc_function_config pfc_fc_props chk_u (.clk_sys, .rstn, .regWrite, .regAddr, .regWdata,
   .regRaddr, .regRdata, .aux_source_select, .ratio_source_select, .pllLocked, .auxPinOe,
   .clockOutEnable, .skip_tolerance_enable, .refDivide, .prescaleReserved, .ratioFractionHigh,
   .bandwidthHz);

// file: testbench.sv
// self-checking bench for the function configuration registers
`timescale 1ns/1ps
module testbench;
   logic clk_sys, rstn, ratio_source_select, pllLocked, syncPulseMissing, auxClock;
   logic [1:0] aux_source_select, ratioIndex;
   wire regWrite, auxPinOut, auxPinOe, clockOutEnable, skip_tolerance_enable, holdLock;
   wire prescaleReserved, ratioFractionHigh, bandwidthPending;
   wire [7:0] regAddr, regWdata, regRaddr, regRdata, bandwidthHz;
   wire [2:0] refDivide;
   wire [31:0] user_ratio;
   int err_count = 0, total_checks = 0;
   logic [7:0] q;
   // address, write data, expected read back
   logic [23:0] rows [5] = '{24'h16ffd8, 24'h17ff18, 24'h1eff70, 24'h20ff00, 24'h055a00};
   // 12.20 ratio 1.2288 then 20.12 ratio 204800
   logic [63:0] rv = 64'h0013a92a_32000000;
   pfc_host_model h (.clk_sys, .regRdata, .regWrite, .regAddr, .regWdata, .regRaddr);
   pfc_function_config dut_u (.clk_sys, .rstn, .regWrite, .regAddr, .regWdata, .regRaddr,
      .regRdata, .aux_source_select, .ratio_source_select, .ratioIndex, .pllLocked,
      .syncPulseMissing, .auxClock, .auxPinOut, .auxPinOe, .clockOutEnable,
      .skip_tolerance_enable, .holdLock, .refDivide, .prescaleReserved, .ratioFractionHigh,
      .user_ratio, .bandwidthHz, .bandwidthPending);
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task test_done;
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // lock input passes a synchroniser, so allow settling time
   task lock(input logic v);
      @(posedge clk_sys) pllLocked <= v;
      w(8);
   endtask
   initial begin
      {rstn, aux_source_select, ratio_source_select, ratioIndex} = 6'h0;
      {pllLocked, syncPulseMissing, auxClock} = 3'h0;
      w(3);
      chk("refDivide", 4, refDivide);
      chk("ratioFractionHigh", 1, ratioFractionHigh);
      @(posedge clk_sys) rstn <= 1'b1;
      foreach (rows[i]) begin
         h.wr(rows[i][23:16], rows[i][15:8]);
         h.rd(rows[i][23:16], q);
         chk("regRdata", rows[i][7:0], q);
      end
      chk("skip", 1, skip_tolerance_enable);
      chk("prescaleReserved", 1, prescaleReserved);
      chk("refDivide", 4, refDivide);
      for (int k = 0; k < 8; k++) begin
         h.wr(8'h1e, 8'(k << 4));
         if (k < 3) h.wr(8'h16, 8'(k << 3));
         w(2);
         chk("bandwidthHz", 1 << k, bandwidthHz);
         if (k < 3) chk("refDivide", 3'h4 >> k, refDivide);
      end
      @(posedge clk_sys) ratio_source_select <= 1'h1;
      h.wr(8'h17, 8'h00);
      w(3);
      chk("ratioFractionHigh", 0, ratioFractionHigh);
      h.wr(8'h17, 8'h08);
      w(2);
      chk("ratioFractionHigh", 1, ratioFractionHigh);
      @(posedge clk_sys) ratio_source_select <= 1'h0;
      h.wr(8'h17, 8'h00);
      w(3);
      chk("ratioFractionHigh", 1, ratioFractionHigh);
      @(posedge clk_sys) aux_source_select <= 2'h3;
      w(3);
      chk("aux out", 2'h3, {auxPinOut, auxPinOe});
      chk("clockOutEnable", 0, clockOutEnable);
      lock(1);
      chk("aux out", 2'h1, {auxPinOut, auxPinOe});
      chk("clockOutEnable", 1, clockOutEnable);
      h.wr(8'h16, 8'h40);
      w(2);
      chk("aux oe", 0, auxPinOe);
      lock(0);
      chk("aux out", 2'h1, {auxPinOut, auxPinOe});
      h.wr(8'h17, 8'h10);
      w(2);
      chk("clockOutEnable", 1, clockOutEnable);
      @(posedge clk_sys) {aux_source_select, auxClock} <= 3'h3;
      w(8);
      chk("aux clock", 2'h3, {auxPinOut, auxPinOe});
      lock(1);
      h.wr(8'h1e, 8'h00);
      w(2);
      chk("bandwidthPending", 1, bandwidthPending);
      chk("bandwidthHz", 128, bandwidthHz);
      lock(0);
      chk("bandwidthHz", 1, bandwidthHz);
      h.wr(8'h16, 8'h80);
      lock(1);
      @(posedge clk_sys) syncPulseMissing <= 1'h1;
      w(8);
      chk("holdLock", 1, holdLock);
      @(posedge clk_sys) syncPulseMissing <= 1'h0;
      for (int i = 0; i < 8; i++) h.wr(8'h06 + 8'(i), rv[63 - 8 * i -: 8]);
      w(2);
      chk("user_ratio", rv[63:32], user_ratio);
      @(posedge clk_sys) ratioIndex <= 2'h1;
      w(3);
      chk("user_ratio", rv[31:0], user_ratio);
      // ratio two straddles the 0x0f to 0x10 address boundary
      for (int i = 0; i < 4; i++) h.wr(8'h0e + 8'(i), rv[63 - 8 * i -: 8]);
      @(posedge clk_sys) ratioIndex <= 2'h2;
      w(3);
      chk("user_ratio", rv[63:32], user_ratio);
      // mid-run reset clears registers and derived outputs
      @(posedge clk_sys) rstn <= 1'h0;
      w(2);
      chk("user_ratio", 0, user_ratio);
      chk("skip", 0, skip_tolerance_enable);
      @(posedge clk_sys) rstn <= 1'h1;
      h.rd(8'h16, q);
      chk("regRdata", 0, q);
      test_done;
   end
   // cuts a hang short
   initial begin
      #100000;
      err_count++;
      test_done;
   end
endmodule
